// >>> design/socb_pkg.sv
package socb_pkg;
   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_MODE_LOCK_MASK = 8'h9A;
   localparam logic [7:0] ADDR_LINE_NUMBERED = 8'h9C;
   localparam logic [7:0] ADDR_LINE_LETTERED = 8'h9E;
   localparam logic [7:0] ADDR_ANGLE_OFFSET = 8'hA0;
   localparam logic [7:0] ADDR_INTERFACE_MODE = 8'hA2;
   localparam logic [15:0] UNMAPPED_READ = 16'h0000;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int BIT_OV_DISABLE = 15;
   localparam int BIT_SPIKE = 14;
   localparam int BIT_OD_HIGH = 11;
   localparam int BIT_OD_MID = 9;
   localparam int BIT_OD_LOW = 7;
   localparam int BIT_SLOPE_HI = 15;
   localparam int BIT_SLOPE_LO = 14;
   localparam int BIT_ANGLE_HI = 15;
   localparam int BIT_ANGLE_LO = 2;
   localparam int BIT_ROT_SENSE = 1;
   localparam int BIT_ANGLE_RSVD = 0;
   localparam logic [15:0] ANGLE_RSVD_MASK = 16'h0001;
   localparam int NVM_WORDS = 5;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      SLOPE_2US = 2'b00,
      SLOPE_4US = 2'b01,
      SLOPE_6US = 2'b10,
      SLOPE_TRISTATE = 2'b11
   } socb_slope_type;
   typedef struct packed {
      logic overvoltageCutoffDisable;
      logic spikeFilterEnable;
      logic out1OpenDrain;
      logic out2OpenDrain;
      logic out3OpenDrain;
      logic outaOpenDrain;
      logic outbOpenDrainEdge;
      logic outcOpenDrain;
   } socb_pad_type;
   typedef struct packed {
      logic [13:0] angleOffset;
      logic rotationSense;
   } socb_angle_type;
endpackage

// >>> design/socb_pad_decode.sv
`timescale 1ns/10ps
module socb_pad_decode
   import socb_pkg::*;
(
   input wire logic [15:0] lineNumbered,
   input wire logic [15:0] lineLettered,
   input wire logic [15:0] angleWord,
   output socb_pad_type pad,
   output socb_slope_type slope,
   output socb_angle_type angle
);
   always_comb begin
      pad.overvoltageCutoffDisable = lineNumbered[BIT_OV_DISABLE];
      pad.spikeFilterEnable = lineNumbered[BIT_SPIKE];
      pad.out3OpenDrain = lineNumbered[BIT_OD_HIGH];
      pad.out2OpenDrain = lineNumbered[BIT_OD_MID];
      pad.out1OpenDrain = lineNumbered[BIT_OD_LOW];
      pad.outcOpenDrain = lineLettered[BIT_OD_HIGH];
      pad.outbOpenDrainEdge = lineLettered[BIT_OD_MID];
      pad.outaOpenDrain = lineLettered[BIT_OD_LOW];
      slope = socb_slope_type'(lineLettered[BIT_SLOPE_HI:BIT_SLOPE_LO]);
      angle.angleOffset = angleWord[BIT_ANGLE_HI:BIT_ANGLE_LO];
      angle.rotationSense = angleWord[BIT_ROT_SENSE];
   end
endmodule // socb_pad_decode

// >>> design/socb_sensor_output_config_bank.sv
`timescale 1ns/10ps
module socb_sensor_output_config_bank
   import socb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [15:0] writedata,
   output logic [15:0] readdata,
   output logic waitrequest,
   input wire logic [15:0] nvmMask,
   input wire logic [15:0] nvmNumbered,
   input wire logic [15:0] nvmLettered,
   input wire logic [15:0] nvmAngle,
   input wire logic [15:0] nvmMode,
   input wire logic overvoltageFlag,
   input wire logic [5:0] lineDataIn,
   output logic [15:0] interfaceModeEffective,
   output socb_pad_type padConfig,
   output socb_slope_type slopeSel,
   output socb_angle_type angleConfig,
   output logic [5:0] lineOut,
   output logic [5:0] lineOe,
   output logic outputsActive,
   output logic loaded
);
   // ****************************************
   // Working copies and bus state
   // ****************************************
   logic [15:0] modeLockMask;
   logic [15:0] lineNumbered;
   logic [15:0] lineLettered;
   logic [15:0] angleWord;
   logic [15:0] interfaceMode;
   logic pending;
   logic [2:0] ovSync;
   logic ovStable;
   logic [15:0] next_readdata;
   socb_pad_type decodedPad;
   socb_slope_type decodedSlope;
   socb_angle_type decodedAngle;
   logic accessNow;

   // One wait cycle per access: request taken, answered next edge
   assign accessNow = (read || write) && pending;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pending <= 1'b0;
      end else if (pending) begin
         pending <= 1'b0;
      end else begin
         pending <= read || write;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && !pending);
      end
   end

   // ****************************************
   // Nonvolatile copy and software writes
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         loaded <= 1'b0;
      end else begin
         loaded <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         modeLockMask <= 16'h0000;
         lineNumbered <= 16'h0000;
         lineLettered <= 16'h0000;
         angleWord <= 16'h0000;
         interfaceMode <= 16'h0000;
      end else if (!loaded) begin
         modeLockMask <= nvmMask;
         lineNumbered <= nvmNumbered;
         lineLettered <= nvmLettered;
         angleWord <= nvmAngle & ~ANGLE_RSVD_MASK;
         interfaceMode <= nvmMode;
      end else if (write && accessNow) begin
         case (address)
            ADDR_MODE_LOCK_MASK: modeLockMask <= writedata;
            ADDR_LINE_NUMBERED: lineNumbered <= writedata;
            ADDR_LINE_LETTERED: lineLettered <= writedata;
            ADDR_ANGLE_OFFSET: begin
               // Reserved bit 0 held at zero
               angleWord <= writedata & ~ANGLE_RSVD_MASK;
            end
            ADDR_INTERFACE_MODE: interfaceMode <= writedata;
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always_comb begin
      case (address)
         ADDR_MODE_LOCK_MASK: next_readdata = modeLockMask;
         ADDR_LINE_NUMBERED: next_readdata = lineNumbered;
         ADDR_LINE_LETTERED: next_readdata = lineLettered;
         ADDR_ANGLE_OFFSET: next_readdata = angleWord;
         ADDR_INTERFACE_MODE: next_readdata = interfaceMode;
         default: next_readdata = UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         readdata <= 16'h0000;
      end else if (read && !pending) begin
         readdata <= next_readdata;
      end
   end

   // ****************************************
   // Decoded configuration
   // ****************************************
   socb_pad_decode socb_pad_decode_i (
      .lineNumbered(lineNumbered),
      .lineLettered(lineLettered),
      .angleWord(angleWord),
      .pad(decodedPad),
      .slope(decodedSlope),
      .angle(decodedAngle)
   );

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         interfaceModeEffective <= 16'h0000;
         padConfig <= '0;
         slopeSel <= SLOPE_2US;
         angleConfig <= '0;
      end else begin
         interfaceModeEffective <= interfaceMode & modeLockMask;
         padConfig <= decodedPad;
         slopeSel <= decodedSlope;
         angleConfig <= decodedAngle;
      end
   end

   // ****************************************
   // Overvoltage flag synchroniser
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ovSync <= 3'b000;
         ovStable <= 1'b0;
      end else begin
         ovSync <= {ovSync[1:0], overvoltageFlag};
         if (ovSync[1] == ovSync[2]) begin
            ovStable <= ovSync[2];
         end
      end
   end

   // ****************************************
   // Output pad drive
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         outputsActive <= 1'b0;
      end else begin
         outputsActive <= !(ovStable && !lineNumbered[BIT_OV_DISABLE])
            && (decodedSlope != SLOPE_TRISTATE);
      end
   end

   // Open drain drives only low; push-pull drives both levels
   function automatic logic odEnable(input logic openDrain, input logic level);
      odEnable = openDrain ? !level : 1'b1;
   endfunction

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lineOut <= 6'h00;
         lineOe <= 6'h00;
      end else begin
         lineOut <= lineDataIn;
         for (int i = 0; i < 6; i++) begin
            lineOe[i] <= 1'b0;
         end
         if (!(ovStable && !lineNumbered[BIT_OV_DISABLE])
               && decodedSlope != SLOPE_TRISTATE) begin
            lineOe[0] <= odEnable(decodedPad.out1OpenDrain, lineDataIn[0]);
            lineOe[1] <= odEnable(decodedPad.out2OpenDrain, lineDataIn[1]);
            lineOe[2] <= odEnable(decodedPad.out3OpenDrain, lineDataIn[2]);
            lineOe[3] <= odEnable(decodedPad.outaOpenDrain, lineDataIn[3]);
            lineOe[4] <= odEnable(decodedPad.outbOpenDrainEdge, lineDataIn[4]);
            lineOe[5] <= odEnable(decodedPad.outcOpenDrain, lineDataIn[5]);
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   property p_lock_and;
      @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> interfaceModeEffective == ($past(interfaceMode) & $past(modeLockMask));
   endproperty
   a_lock_and: assert property (p_lock_and) else $error("lock AND wrong");

   property p_readback_unmasked;
      @(posedge clk_sys) disable iff (!rst_n)
      (read && !pending && address == ADDR_INTERFACE_MODE) |=>
         readdata == $past(interfaceMode);
   endproperty
   a_readback_unmasked: assert property (p_readback_unmasked) else $error("mode readback");

   property p_ov_cut;
      @(posedge clk_sys) disable iff (!rst_n)
      (ovStable && !lineNumbered[BIT_OV_DISABLE] && loaded) |=> lineOe == 6'h00;
   endproperty
   a_ov_cut: assert property (p_ov_cut) else $error("overvoltage not cut");

   property p_spike;
      @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> padConfig.spikeFilterEnable == $past(lineNumbered[BIT_SPIKE]);
   endproperty
   a_spike: assert property (p_spike) else $error("spike filter bit");

   property p_pushpull_drive;
      @(posedge clk_sys) disable iff (!rst_n)
      (!lineNumbered[BIT_OD_LOW] && !ovStable && decodedSlope != SLOPE_TRISTATE)
         |=> lineOe[0];
   endproperty
   a_pushpull_drive: assert property (p_pushpull_drive) else $error("push-pull not driven");

   property p_od_high_release;
      @(posedge clk_sys) disable iff (!rst_n)
      (lineLettered[BIT_OD_MID] && lineDataIn[4]) |=> !lineOe[4];
   endproperty
   a_od_high_release: assert property (p_od_high_release) else $error("open drain high");

   property p_tristate;
      @(posedge clk_sys) disable iff (!rst_n)
      (lineLettered[BIT_SLOPE_HI:BIT_SLOPE_LO] == 2'b11) |=> (lineOe == 6'h00 && !outputsActive);
   endproperty
   a_tristate: assert property (p_tristate) else $error("tristate not applied");

   property p_angle;
      @(posedge clk_sys) disable iff (!rst_n)
      1'b1 |=> (angleConfig.angleOffset == $past(angleWord[BIT_ANGLE_HI:BIT_ANGLE_LO])
         && angleConfig.rotationSense == $past(angleWord[BIT_ROT_SENSE]));
   endproperty
   a_angle: assert property (p_angle) else $error("angle decode");

   sequence s_released;
      !loaded ##1 loaded;
   endsequence
   property p_copy;
      @(posedge clk_sys) disable iff (!rst_n)
      s_released |-> modeLockMask == $past(nvmMask);
   endproperty
   a_copy: assert property (p_copy) else $error("nvm copy missing");

   property p_ov_disabled;
      @(posedge clk_sys) disable iff (!rst_n)
      (lineNumbered[BIT_OV_DISABLE] && decodedSlope != SLOPE_TRISTATE) |=> outputsActive;
   endproperty
   a_ov_disabled: assert property (p_ov_disabled) else $error("cut while disabled");

   property p_od_line3_release;
      @(posedge clk_sys) disable iff (!rst_n)
      (lineNumbered[BIT_OD_HIGH] && lineDataIn[2]) |=> !lineOe[2];
   endproperty
   a_od_line3_release: assert property (p_od_line3_release) else $error("line 3 od high");

   property p_od_linec_release;
      @(posedge clk_sys) disable iff (!rst_n)
      (lineLettered[BIT_OD_HIGH] && lineDataIn[5]) |=> !lineOe[5];
   endproperty
   a_od_linec_release: assert property (p_od_linec_release) else $error("line C od high");

   property p_wait_answer;
      @(posedge clk_sys) disable iff (!rst_n)
      ((read || write) && !pending) |=> !waitrequest;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("access not answered");

   // Mask write taken, then lands on the answering edge
   sequence s_mask_taken;
      (write && !pending && address == ADDR_MODE_LOCK_MASK) ##1 (write && pending && loaded);
   endsequence
   property p_mask_write;
      @(posedge clk_sys) disable iff (!rst_n)
      s_mask_taken |=> modeLockMask == $past(writedata);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write lost");
endmodule // socb_sensor_output_config_bank

// >>> test/socb_sensor_output_config_bank_test.sv
`timescale 1ns/10ps
module socb_sensor_output_config_bank_test
   import socb_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [15:0] writedata = 16'h0000;
   logic [15:0] readdata;
   logic waitrequest;
   logic [15:0] nvmMask = 16'h00FF;
   logic [15:0] nvmNumbered = 16'h4540;
   logic [15:0] nvmLettered = 16'h4280;
   logic [15:0] nvmAngle = 16'h0006;
   logic [15:0] nvmMode = 16'hF0F0;
   logic overvoltageFlag = 1'b0;
   logic [5:0] lineDataIn = 6'h00;
   logic [15:0] interfaceModeEffective;
   socb_pad_type padConfig;
   socb_slope_type slopeSel;
   socb_angle_type angleConfig;
   logic [5:0] lineOut;
   logic [5:0] lineOe;
   logic outputsActive;
   logic loaded;
   int nErrors = 0;
   int checked = 0;
   int cycles = 0;
   logic [15:0] rd;
   logic [15:0] numTab [4] = '{16'h85C0, 16'h4740, 16'hCD40, 16'h0FC0};
   logic [15:0] letTab [4] = '{16'h0080, 16'h4200, 16'h8800, 16'hCA80};
   logic [5:0] od;
   logic [5:0] expOe;
   socb_sensor_output_config_bank socb_sensor_output_config_bank_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .nvmMask(nvmMask), .nvmNumbered(nvmNumbered), .nvmLettered(nvmLettered),
      .nvmAngle(nvmAngle), .nvmMode(nvmMode), .overvoltageFlag(overvoltageFlag),
      .lineDataIn(lineDataIn), .interfaceModeEffective(interfaceModeEffective),
      .padConfig(padConfig), .slopeSel(slopeSel), .angleConfig(angleConfig),
      .lineOut(lineOut), .lineOe(lineOe), .outputsActive(outputsActive), .loaded(loaded));
   // ****************************************
   // Clock and timeout
   // ****************************************
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         nErrors = nErrors + 1;
         final_report();
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         nErrors = nErrors + 1;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q);
      address <= a;
      writedata <= d;
      read <= ~wr;
      write <= wr;
      do begin
         @(posedge clk_sys);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] q;
      bus(1'b0, a, 16'h0000, q);
      check(q, exp);
   endtask
   task automatic settle();
      repeat (3) @(posedge clk_sys);
   endtask
   function automatic socb_pad_type padExp(input logic [15:0] n, input logic [15:0] l);
      return '{n[15], n[14], n[7], n[9], n[11], l[7], l[9], l[11]};
   endfunction
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      settle();
      check(loaded, 1'b1);
      rdchk(ADDR_MODE_LOCK_MASK, 16'h00FF);
      rdchk(ADDR_LINE_NUMBERED, 16'h4540);
      rdchk(ADDR_LINE_LETTERED, 16'h4280);
      rdchk(ADDR_ANGLE_OFFSET, 16'h0006);
      rdchk(ADDR_INTERFACE_MODE, 16'hF0F0);
      check(interfaceModeEffective, 16'h00F0);
      check(padConfig, padExp(16'h4540, 16'h4280));
      check(slopeSel, SLOPE_4US);
      check(angleConfig, {14'h0001, 1'b1});
      $display("test reset load done");
      wr(ADDR_MODE_LOCK_MASK, 16'h0F3C);
      wr(ADDR_INTERFACE_MODE, 16'hFFFF);
      rdchk(ADDR_INTERFACE_MODE, 16'hFFFF);
      settle();
      check(interfaceModeEffective, 16'h0F3C);
      wr(ADDR_INTERFACE_MODE, 16'h5A5A);
      settle();
      check(interfaceModeEffective, 16'h0A18);
      $display("test lock mask done");
      for (int i = 0; i < 4; i++) begin
         lineDataIn <= 6'h2A ^ 6'(i * 7);
         wr(ADDR_LINE_NUMBERED, numTab[i]);
         wr(ADDR_LINE_LETTERED, letTab[i]);
         settle();
         check(padConfig, padExp(numTab[i], letTab[i]));
         check(slopeSel, letTab[i][15:14]);
         rdchk(ADDR_LINE_LETTERED, letTab[i]);
         od = {letTab[i][11], letTab[i][9], letTab[i][7],
               numTab[i][11], numTab[i][9], numTab[i][7]};
         for (int j = 0; j < 6; j++) begin
            expOe[j] = (letTab[i][15:14] != 2'b11) && (od[j] ? ~lineDataIn[j] : 1'b1);
         end
         check(outputsActive, letTab[i][15:14] != 2'b11);
         check(lineOe, expOe);
         check(lineOut & lineOe, lineDataIn & expOe);
      end
      $display("test pad decode done");
      wr(ADDR_LINE_NUMBERED, 16'h0540);
      wr(ADDR_LINE_LETTERED, 16'h0000);
      overvoltageFlag <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check(outputsActive, 1'b0);
      check(lineOe, 6'h00);
      overvoltageFlag <= 1'b0;
      repeat (8) @(posedge clk_sys);
      check(outputsActive, 1'b1);
      wr(ADDR_LINE_NUMBERED, 16'h8540);
      overvoltageFlag <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check(outputsActive, 1'b1);
      overvoltageFlag <= 1'b0;
      $display("test overvoltage done");
      wr(ADDR_ANGLE_OFFSET, 16'h8002);
      rdchk(ADDR_ANGLE_OFFSET, 16'h8002);
      settle();
      check(angleConfig, {14'h2000, 1'b1});
      wr(ADDR_ANGLE_OFFSET, 16'h7FFC);
      rdchk(ADDR_ANGLE_OFFSET, 16'h7FFC);
      settle();
      check(angleConfig, {14'h1FFF, 1'b0});
      $display("test angle done");
      wr(ADDR_LINE_NUMBERED, 16'h0540);
      bus(1'b0, ADDR_LINE_NUMBERED, 16'h0000, rd);
      wr(ADDR_LINE_NUMBERED, (rd & 16'h0540) | 16'h4880);
      rdchk(ADDR_LINE_NUMBERED, 16'h4DC0);
      settle();
      check(padConfig, padExp(16'h4DC0, 16'h0000));
      $display("test reserved bits done");
      wr(8'h10, 16'hFFFF);
      rdchk(8'h10, UNMAPPED_READ);
      rdchk(ADDR_MODE_LOCK_MASK, 16'h0F3C);
      $display("test unmapped done");
      final_report();
   end
endmodule // socb_sensor_output_config_bank_test
